// ---- rtl/general_purpose_pin_port.sv ----
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// - Clock gated until power controller enables it
// - Thirty-two individually controllable pins
// - Two banks of sixteen pins
// - 32-bit registers, pin N at bit N
// - Way bit zero drives pin from latch
// - Way bit one leaves pin undriven
// - Set port drives ones high
// - Clear port drives ones low
// - Latch write replaces every byte-enabled bit
// - Set, clear, latch read return latch
// - Data writes do not affect input pins
// - Sample register returns synchronised input level
// - Sample register returns driven value for outputs
// - Open-drain pins read wired level
// - Software reset keeps configuration and state
// - Power controller reset restores configuration defaults
// - Hardware reset restores all registers
// - Raise interrupt events toward processor
// - Rising, falling, both or no edge
// - Per-bank event enable, bit 0 bank 0
// - Pending flag reads one, write one clears
module general_purpose_pin_port
    import gpin_pkg::*;
#(
    parameter int PINS = PIN_CNT
) (
    input  wire logic              clk_sys_i,      // Peripheral clock
    input  wire logic              nrst_i,         // Hardware reset, async low
    input  wire logic              pwr_clk_en_i,   // Clock enable from power gate
    input  wire logic              pwr_rst_i,      // Power controller reset, high
    input  wire logic              sw_rst_i,       // Software reset, no effect
    input  wire logic [REG_AW-1:0] avs_address,    // Byte address
    input  wire logic              avs_read,       // Read strobe
    input  wire logic              avs_write,      // Write strobe
    input  wire logic [31:0]       avs_writedata,  // Write data
    input  wire logic [3:0]        avs_byteenable, // Byte enables
    output logic [31:0]            avs_readdata,   // Read data
    output logic                   avs_waitrequest,// Wait request
    input  wire logic [PINS-1:0]   general_pins_i, // Pin level in
    input  wire logic [PINS-1:0]   pin_open_drain_i, // Pin has open-drain buffer
    output logic [PINS-1:0]        general_pins_o, // Pin drive value
    output logic [PINS-1:0]        general_pins_oe_o, // Pin drive enable
    output logic [PINS-1:0]        pin_event_o,    // Per-pin event pulse
    output logic [BANK_CNT-1:0]    bank_event_o    // Per-bank event pulse
);

    typedef struct packed {
        bus_state_t          bus;
        logic [31:0]         rdata;
        logic [PINS-1:0]     way;
        logic [PINS-1:0]     latch;
        logic [PINS-1:0]     sync1;
        logic [PINS-1:0]     sync2;
        logic [PINS-1:0]     sample;
        logic [PINS-1:0]     prev;
        logic                prev_ok;
        logic [PINS-1:0]     rise_arm;
        logic [PINS-1:0]     fall_arm;
        logic [PINS-1:0]     pending;
        logic [BANK_CNT-1:0] bank_en;
        logic [PINS-1:0]     pin_ev;
        logic [BANK_CNT-1:0] bank_ev;
        logic [PINS-1:0]     pad_o;
        logic [PINS-1:0]     pad_oe;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic [31:0] wmask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] widen(input logic [PINS-1:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[PINS-1:0] = v;
        return w;
    endfunction

    // Masked replace of a whole register
    function automatic logic [PINS-1:0] merge(
        input logic [PINS-1:0] old_v,
        input logic [PINS-1:0] new_v,
        input logic [PINS-1:0] m
    );
        return (old_v & ~m) | (new_v & m);
    endfunction

    // Write-one-to-set
    function automatic logic [PINS-1:0] set_bits(
        input logic [PINS-1:0] old_v,
        input logic [PINS-1:0] m
    );
        return old_v | m;
    endfunction

    // Write-one-to-clear
    function automatic logic [PINS-1:0] clr_bits(
        input logic [PINS-1:0] old_v,
        input logic [PINS-1:0] m
    );
        return old_v & ~m;
    endfunction

    // Armed low-to-high changes of the sampled level
    function automatic logic [PINS-1:0] edge_up(
        input logic [PINS-1:0] cur,
        input logic [PINS-1:0] old_v,
        input logic [PINS-1:0] arm
    );
        return cur & ~old_v & arm;
    endfunction

    // Armed high-to-low changes of the sampled level
    function automatic logic [PINS-1:0] edge_down(
        input logic [PINS-1:0] cur,
        input logic [PINS-1:0] old_v,
        input logic [PINS-1:0] arm
    );
        return ~cur & old_v & arm;
    endfunction

    // Drop events of banks that are not enabled
    function automatic logic [PINS-1:0] bank_gate(
        input logic [PINS-1:0]     v,
        input logic [BANK_CNT-1:0] en
    );
        logic [PINS-1:0] g;
        g = v;
        for (int b = 0; b < BANK_CNT; b++) begin
            g[b*BANK_PINS +: BANK_PINS] = v[b*BANK_PINS +: BANK_PINS] & {BANK_PINS{en[b]}};
        end
        return g;
    endfunction

    // Any event per bank
    function automatic logic [BANK_CNT-1:0] bank_any(input logic [PINS-1:0] v);
        logic [BANK_CNT-1:0] a;
        a = '0;
        for (int b = 0; b < BANK_CNT; b++) begin
            a[b] = |v[b*BANK_PINS +: BANK_PINS];
        end
        return a;
    endfunction

    // Outputs read own drive, inputs and open-drain read the wire
    function automatic logic [PINS-1:0] pin_view(
        input logic [PINS-1:0] way,
        input logic [PINS-1:0] od,
        input logic [PINS-1:0] latch,
        input logic [PINS-1:0] lvl
    );
        logic [PINS-1:0] own;
        logic [PINS-1:0] ext;
        own = ~way & ~od;
        ext = way | od;
        return (own & latch) | (ext & lvl);
    endfunction

    // Register word for a read offset
    function automatic logic [31:0] read_word(
        input logic [REG_AW-1:0] addr,
        input state_t            s
    );
        logic [31:0] r;
        r = UNMAPPED_VALUE;
        unique case (addr)
            OFS_IDENT: begin
                r = IDENT_VALUE;
            end
            OFS_BANK_IRQ_EN: begin
                r[BANK_CNT-1:0] = s.bank_en;
            end
            OFS_WAY_SELECT: begin
                r = widen(s.way);
            end
            OFS_OUT_LATCH,
            OFS_OUT_SET,
            OFS_OUT_CLEAR: begin
                r = widen(s.latch);
            end
            OFS_PIN_SAMPLE: begin
                r = widen(s.sample);
            end
            OFS_RISE_ARM,
            OFS_RISE_DISARM: begin
                r = widen(s.rise_arm);
            end
            OFS_FALL_ARM,
            OFS_FALL_DISARM: begin
                r = widen(s.fall_arm);
            end
            OFS_IRQ_PENDING: begin
                r = widen(s.pending);
            end
            default: begin
                r = UNMAPPED_VALUE;
            end
        endcase
        return r;
    endfunction

    logic [31:0]     lane;
    logic [PINS-1:0] bm;
    logic [PINS-1:0] wd;
    logic [PINS-1:0] wm;
    logic [PINS-1:0] live;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;
    logic [PINS-1:0] ev;
    logic            wr_go;
    logic            rd_go;
    logic [31:0]     rd_val;

    always_comb begin
        s_d    = s_q;
        lane   = wmask(avs_byteenable);
        bm     = lane[PINS-1:0];
        wd     = avs_writedata[PINS-1:0];
        wm     = wd & bm;
        wr_go  = 1'b0;
        rd_go  = 1'b0;
        rd_val = UNMAPPED_VALUE;
        rise   = '0;
        fall   = '0;
        ev     = '0;
        live   = '0;

        // Read data loaded on acceptance so it stands while waitrequest is low
        unique case (s_q.bus)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    s_d.bus = BUS_ACK;
                    rd_go   = avs_read;
                end
            end
            BUS_ACK: begin
                s_d.bus = BUS_IDLE;
                wr_go   = avs_write;
            end
            default: begin
                s_d.bus = BUS_IDLE;
            end
        endcase

        // Pin synchroniser, second stage read only
        s_d.sync1 = general_pins_i;
        s_d.sync2 = s_q.sync1;
        // Outputs read own drive, open-drain and inputs read the wire
        live       = pin_view(s_q.way, pin_open_drain_i, s_q.latch, s_q.sync2);
        s_d.sample = live;

        if (pwr_clk_en_i) begin
            // Edge detect on synchronised level, both directions
            s_d.prev    = live;
            s_d.prev_ok = 1'b1;
            if (s_q.prev_ok) begin
                rise = edge_up(live, s_q.prev, s_q.rise_arm);
                fall = edge_down(live, s_q.prev, s_q.fall_arm);
            end
            ev = bank_gate(rise | fall, s_q.bank_en);

            if (rd_go) begin
                rd_val = read_word(avs_address, s_q);
            end

            if (wr_go) begin
                unique case (avs_address)
                    OFS_BANK_IRQ_EN: begin
                        s_d.bank_en = (s_q.bank_en & ~lane[BANK_CNT-1:0])
                                    | (avs_writedata[BANK_CNT-1:0] & lane[BANK_CNT-1:0]);
                    end
                    OFS_WAY_SELECT: begin
                        s_d.way = merge(s_q.way, wd, bm);
                    end
                    OFS_OUT_LATCH: begin
                        s_d.latch = merge(s_q.latch, wd, bm);
                    end
                    OFS_OUT_SET: begin
                        s_d.latch = set_bits(s_q.latch, wm);
                    end
                    OFS_OUT_CLEAR: begin
                        s_d.latch = clr_bits(s_q.latch, wm);
                    end
                    OFS_RISE_ARM: begin
                        s_d.rise_arm = set_bits(s_q.rise_arm, wm);
                    end
                    OFS_RISE_DISARM: begin
                        s_d.rise_arm = clr_bits(s_q.rise_arm, wm);
                    end
                    OFS_FALL_ARM: begin
                        s_d.fall_arm = set_bits(s_q.fall_arm, wm);
                    end
                    OFS_FALL_DISARM: begin
                        s_d.fall_arm = clr_bits(s_q.fall_arm, wm);
                    end
                    OFS_IRQ_PENDING: begin
                        s_d.pending = clr_bits(s_q.pending, wm);
                    end
                    default: begin
                        s_d.pending = s_q.pending;
                    end
                endcase
            end
            // New events win over a same-cycle clear
            s_d.pending = s_d.pending | ev;
        end else if (rd_go) begin
            rd_val = UNMAPPED_VALUE;
        end

        s_d.pin_ev = ev;
        s_d.bank_ev = bank_any(ev);
        if (rd_go) begin
            s_d.rdata = rd_val;
        end

        // Pads: latch drives outputs, inputs never driven
        s_d.pad_o  = s_d.latch;
        s_d.pad_oe = ~s_d.way;

        // Power controller reset restores configuration and clears pending flags, latch kept
        if (pwr_rst_i) begin
            s_d.way      = RST_WAY_SELECT[PINS-1:0];
            s_d.rise_arm = RST_ZERO[PINS-1:0];
            s_d.fall_arm = RST_ZERO[PINS-1:0];
            s_d.bank_en  = RST_ZERO[BANK_CNT-1:0];
            s_d.pending  = RST_ZERO[PINS-1:0];
            s_d.pad_oe   = RST_ZERO[PINS-1:0];
            s_d.prev_ok  = 1'b0;
        end
    end

    // Soft reset input drives no state, so pins survive it
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.bus      <= BUS_IDLE;
            s_q.rdata    <= RST_ZERO;
            s_q.way      <= RST_WAY_SELECT[PINS-1:0];
            s_q.latch    <= RST_ZERO[PINS-1:0];
            s_q.sync1    <= RST_ZERO[PINS-1:0];
            s_q.sync2    <= RST_ZERO[PINS-1:0];
            s_q.sample   <= RST_ZERO[PINS-1:0];
            s_q.prev     <= RST_ZERO[PINS-1:0];
            s_q.prev_ok  <= 1'b0;
            s_q.rise_arm <= RST_ZERO[PINS-1:0];
            s_q.fall_arm <= RST_ZERO[PINS-1:0];
            s_q.pending  <= RST_ZERO[PINS-1:0];
            s_q.bank_en  <= RST_ZERO[BANK_CNT-1:0];
            s_q.pin_ev   <= RST_ZERO[PINS-1:0];
            s_q.bank_ev  <= RST_ZERO[BANK_CNT-1:0];
            s_q.pad_o    <= RST_ZERO[PINS-1:0];
            s_q.pad_oe   <= RST_ZERO[PINS-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata      = s_q.rdata;
    assign avs_waitrequest   = (s_q.bus == BUS_IDLE);
    assign general_pins_o    = s_q.pad_o;
    assign general_pins_oe_o = s_q.pad_oe;
    assign pin_event_o       = s_q.pin_ev;
    assign bank_event_o      = s_q.bank_ev;

endmodule

// ---- inc/gpin_pkg.sv ----
package gpin_pkg;

    localparam int          REG_AW           = 6;
    localparam int          PIN_CNT          = 32;
    localparam int          BANK_PINS        = 16;
    localparam int          BANK_CNT         = 2;
    localparam logic [31:0] CPU_PER_PCLK     = 32'h0000_0006;
    // Byte offsets of the register words
    localparam logic [5:0]  OFS_IDENT        = 6'h00;
    localparam logic [5:0]  OFS_BANK_IRQ_EN  = 6'h08;
    localparam logic [5:0]  OFS_WAY_SELECT   = 6'h10;
    localparam logic [5:0]  OFS_OUT_LATCH    = 6'h14;
    localparam logic [5:0]  OFS_OUT_SET      = 6'h18;
    localparam logic [5:0]  OFS_OUT_CLEAR    = 6'h1c;
    localparam logic [5:0]  OFS_PIN_SAMPLE   = 6'h20;
    localparam logic [5:0]  OFS_RISE_ARM     = 6'h24;
    localparam logic [5:0]  OFS_RISE_DISARM  = 6'h28;
    localparam logic [5:0]  OFS_FALL_ARM     = 6'h2c;
    localparam logic [5:0]  OFS_FALL_DISARM  = 6'h30;
    localparam logic [5:0]  OFS_IRQ_PENDING  = 6'h34;
    // Reset values
    localparam logic [31:0] RST_WAY_SELECT   = 32'hffff_ffff;
    localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
    // Identification word, value arbitrary
    localparam logic [31:0] IDENT_VALUE      = 32'h4000_0100;
    // Answer for unmapped words
    localparam logic [31:0] UNMAPPED_VALUE   = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage

// ---- dv/gpin_checker.sv ----
`timescale 1ns/1ns
module gpin_checker
    import gpin_pkg::*;
#(
    parameter int PINS = PIN_CNT
) (
    input  wire logic              clk_sys_i,        // Clock
    input  wire logic              nrst_i,           // Reset
    input  wire logic              pwr_clk_en_i,     // Clock enable
    input  wire logic              pwr_rst_i,        // Power reset
    input  wire logic              sw_rst_i,         // Soft reset
    input  wire logic [REG_AW-1:0] avs_address,      // Address
    input  wire logic              avs_read,         // Read
    input  wire logic              avs_write,        // Write
    input  wire logic [31:0]       avs_writedata,    // Write data
    input  wire logic [3:0]        avs_byteenable,   // Byte enables
    input  wire logic              avs_waitrequest,  // Wait
    input  wire logic [PINS-1:0]   general_pins_o,   // Drive
    input  wire logic [PINS-1:0]   general_pins_oe_o // Enable
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    logic done;
    assign done = avs_write && !avs_waitrequest && avs_byteenable == 4'hf && pwr_clk_en_i && !pwr_rst_i;
    AST_ONE_WAIT: assert property ($rose(avs_read) |=> !avs_waitrequest)
        else $error("read not answered after one wait state");
    AST_ACK_PULSE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_WAY: assert property (done && avs_address == OFS_WAY_SELECT |=>
        general_pins_oe_o == ~$past(avs_writedata[PINS-1:0])) else $error("enable does not follow way bits");
    AST_LATCH: assert property (done && avs_address == OFS_OUT_LATCH |=>
        general_pins_o == $past(avs_writedata[PINS-1:0])) else $error("latch write not taken whole");
    AST_SET: assert property (done && avs_address == OFS_OUT_SET |=>
        general_pins_o == ($past(general_pins_o) | $past(avs_writedata[PINS-1:0]))) else $error("set port wrong");
    AST_CLR: assert property (done && avs_address == OFS_OUT_CLEAR |=>
        general_pins_o == ($past(general_pins_o) & ~$past(avs_writedata[PINS-1:0]))) else $error("clear port wrong");
    AST_GATED: assert property (avs_write && !pwr_clk_en_i |=> $stable(general_pins_o))
        else $error("write took effect while clock gated");
    AST_PWR_REL: assert property (pwr_rst_i && !avs_write |=> general_pins_oe_o == '0)
        else $error("pins not released by power reset");
    AST_SW_KEEP: assert property (sw_rst_i && !avs_write && !pwr_rst_i |=>
        $stable(general_pins_o) && $stable(general_pins_oe_o)) else $error("soft reset changed pins");
endmodule
bind general_purpose_pin_port gpin_checker #(.PINS(PINS)) chk (.clk_sys_i, .nrst_i, .pwr_clk_en_i, .pwr_rst_i,
    .sw_rst_i, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
    .general_pins_o, .general_pins_oe_o);

// ---- dv/pin_world.sv ----
`timescale 1ns/1ns
module pin_world (
    input  wire logic [31:0] drv_i, // Device drive
    input  wire logic [31:0] oe_i,  // Device enable
    input  wire logic [31:0] od_i,  // Open-drain mark
    input  wire logic [31:0] ext_i, // Far-side level
    output logic [31:0]      lvl_o  // Wired level
);
    // Open-drain only pulls low, else the far side decides
    assign lvl_o = (oe_i & ~od_i & drv_i) | (~(oe_i & ~od_i) & ext_i & ~(oe_i & od_i & ~drv_i));
endmodule

// ---- dv/test_general_purpose_pin_port.sv ----
`timescale 1ns/1ns
module test_general_purpose_pin_port
    import gpin_pkg::*;
;
    logic        clk_sys_i = 0, nrst_i = 0, pwr_clk_en_i = 0, pwr_rst_i = 0, sw_rst_i = 0;
    logic        avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [5:0]  avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rdat, ext = '0, od = '0, lvl, po, poe, pev;
    logic [1:0]  bev;
    int          n_fail = 0, tests_run = 0, evn = 0, bvn = 0;
    general_purpose_pin_port uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pwr_clk_en_i(pwr_clk_en_i),
        .pwr_rst_i(pwr_rst_i), .sw_rst_i(sw_rst_i), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .general_pins_i(lvl), .pin_open_drain_i(od), .general_pins_o(po),
        .general_pins_oe_o(poe), .pin_event_o(pev), .bank_event_o(bev));
    pin_world ext_side (.drv_i(po), .oe_i(poe), .od_i(od), .ext_i(ext), .lvl_o(lvl));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (pev[20] === 1'b1) evn <= evn + 1;
        if (bev[1] === 1'b1) bvn <= bvn + 1;
    end
    task automatic end_of_test();
        $display("Checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys_i);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            n_fail++;
            end_of_test();
        end
        rdat = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk_sys_i);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        acc(0, a, '0);
        chk(rdat, e);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1;
        @(posedge clk_sys_i);
        acc(1, OFS_OUT_LATCH, 32'h0000_00ff);
        pwr_clk_en_i <= 1;
        rchk(OFS_WAY_SELECT, 32'hffff_ffff);
        rchk(OFS_OUT_LATCH, 32'h0000_0000);
        rchk(OFS_IDENT, IDENT_VALUE);
        rchk(6'h0c, 32'h0000_0000);
        acc(1, OFS_OUT_LATCH, 32'ha5a5_a5a5);
        chk(poe, 32'h0000_0000);
        acc(1, OFS_WAY_SELECT, 32'hffff_0000);
        chk(po & poe, 32'h0000_a5a5);
        acc(1, OFS_OUT_SET, 32'h0000_000f);
        rchk(OFS_OUT_SET, 32'ha5a5_a5af);
        acc(1, OFS_OUT_CLEAR, 32'h0000_00f0);
        rchk(OFS_OUT_CLEAR, 32'ha5a5_a50f);
        ext <= 32'h1234_fffe;
        od <= 32'h0000_0001;
        repeat (5) @(posedge clk_sys_i);
        rchk(OFS_PIN_SAMPLE, 32'h1234_a50e);
        acc(1, OFS_BANK_IRQ_EN, 32'h0000_0002);
        acc(1, OFS_RISE_ARM, 32'h0010_0000);
        acc(1, OFS_FALL_ARM, 32'h0010_0000);
        acc(1, OFS_FALL_DISARM, 32'h0010_0000);
        ext[20] <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        ext[20] <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk(32'(evn), 32'h0000_0001);
        chk(32'(bvn), 32'h0000_0001);
        rchk(OFS_IRQ_PENDING, 32'h0010_0000);
        acc(1, OFS_IRQ_PENDING, 32'h0010_0000);
        rchk(OFS_IRQ_PENDING, 32'h0000_0000);
        sw_rst_i <= 1;
        repeat (2) @(posedge clk_sys_i);
        sw_rst_i <= 0;
        rchk(OFS_WAY_SELECT, 32'hffff_0000);
        pwr_clk_en_i <= 0;
        @(posedge clk_sys_i);
        pwr_rst_i <= 1;
        repeat (2) @(posedge clk_sys_i);
        pwr_rst_i <= 0;
        pwr_clk_en_i <= 1;
        rchk(OFS_WAY_SELECT, 32'hffff_ffff);
        chk(poe, 32'h0000_0000);
        rchk(OFS_OUT_LATCH, 32'ha5a5_a50f);
        nrst_i <= 0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1;
        @(posedge clk_sys_i);
        rchk(OFS_OUT_LATCH, 32'h0000_0000);
        end_of_test();
    end
endmodule
